// file: inc/ula_defs.vh
// constants for the loop activation control block
`ifndef ULA_DEFS_VH
`define ULA_DEFS_VH
// register byte addresses
`define ULA_ADR_STATUS  5'h00
`define ULA_ADR_CONTROL 5'h04
`define ULA_ADR_CHAN    5'h08
`define ULA_ADR_M4TX    5'h0c
`define ULA_ADR_FSTATE  5'h10
`define ULA_ADR_TIMER   5'h14
// control register fields
`define ULA_CTL_CUST    0
`define ULA_CTL_UPDDIS  1
`define ULA_CTL_DEACT   2
`define ULA_CTL_ACT     3
`define ULA_CTL_NT      4
`define ULA_CTL_IRQEN   5
// other fields
`define ULA_CHAN_SWAP   0
`define ULA_M4_ACT      7
`define ULA_M4_DEA      6
`define ULA_TMR_DIS     0
`define ULA_TMR_AUTO    1
// status values
`define ULA_ST_IDLE     4'h0
`define ULA_ST_PROG     4'h1
`define ULA_ST_ERR      4'h4
`define ULA_ST_NOSYNC   4'h8
`define ULA_ST_NOTRANS  4'ha
`define ULA_ST_UP       4'hb
// framer hold codes
`define ULA_FS_HOLD     4'ha
`define ULA_FS_GO       4'h0
// timing
`define ULA_CLK_NS      8
`define ULA_MS_NS       1000000
`define ULA_TONE_MS     3
`define ULA_ACT_MS      15000
`define ULA_LOSS_MS     480
`define ULA_DEA_SF      3
`endif

// file: verilog/ula_ctrl.v
// loop activation, status and deactivation control with avalon registers
//
// Added by the designer: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`include "ula_defs.vh"

module ula_ctrl #(
    parameter MS_CYC = `ULA_MS_NS / `ULA_CLK_NS
) (
    // clock and reset
    input  wire       clk,
    input  wire       rst_b,
    // avalon-mm slave
    input  wire [4:0] address,
    input  wire       read,
    input  wire       write,
    input  wire [31:0] writedata,
    output reg  [31:0] readdata,
    output wire       waitrequest,
    // line receiver indications
    input  wire       rx_tone_det,
    input  wire       rx_sig_det,
    input  wire       rx_sf_sync,
    input  wire       rx_far_act,
    input  wire       rx_far_deact,
    input  wire       rx_err_high,
    input  wire       rx_m4_dea,
    input  wire       train_done,
    input  wire       sf_tick,
    // transmit framer and timeslot port
    output reg  [3:0] tx_state,
    output reg        tx_m4_act,
    output reg        tx_m4_dea,
    output reg        data_en,
    output reg        chan_en,
    output reg        chan_swap,
    output reg        warm_start,
    output reg        irq_req
);

    // framer states
    localparam [3:0] S_IDLE  = 4'h0;
    localparam [3:0] S_TONE  = 4'h1;
    localparam [3:0] S_QUIET = 4'h2;
    localparam [3:0] S_SL1   = 4'h3;
    localparam [3:0] S_SL2   = 4'h4;
    localparam [3:0] S_SL3   = 4'h5;
    localparam [3:0] S_DEA   = 4'h6;
    localparam [3:0] S_NTTR  = 4'h7;
    localparam [3:0] S_NTUP  = 4'h8;

    reg  [3:0]  st_q;
    reg  [3:0]  lsr_q;
    reg  [5:0]  ctl_q;
    reg         swap_q;
    reg  [1:0]  m4_q;
    reg         hold_q;
    reg  [1:0]  tmr_q;
    reg  [16:0] div_q;
    reg  [13:0] act_ms_q;
    reg  [8:0]  loss_ms_q;
    reg  [1:0]  sf_cnt_q;
    reg         ack_q;
    reg  [3:0]  st_d;
    reg  [3:0]  lsr_d;
    wire        req;
    wire        wr_go;
    wire        rd_go;
    wire        ms_tick;
    wire        act_run;
    wire        tmo;
    wire        up_st;

    ////////////////////////////////////////////////////////////////
    // bus handshake: one wait state per access
    assign req         = read | write;
    assign waitrequest = req & ~ack_q;
    assign wr_go       = write & ack_q;
    assign rd_go       = read & ack_q;

    // wait-state flop
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // read data captured during the wait state
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            readdata <= 32'h0000_0000;
        end else if (req && !ack_q) begin
            case (address)
                `ULA_ADR_STATUS:  readdata <= {28'h000_0000, lsr_q};
                `ULA_ADR_CONTROL: readdata <= {26'h000_0000, ctl_q};
                `ULA_ADR_CHAN:    readdata <= {31'h0000_0000, swap_q};
                `ULA_ADR_M4TX:    readdata <= {24'h00_0000, m4_q, 6'h00};
                `ULA_ADR_FSTATE:  readdata <= {24'h00_0000, st_q, 4'h0};
                `ULA_ADR_TIMER:   readdata <= {30'h0000_0000, tmr_q};
                default:          readdata <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // millisecond enable, restarted when activation starts
    assign ms_tick = (div_q == MS_CYC[16:0] - 17'h00001);
    assign act_run = (st_q == S_TONE) || (st_q == S_QUIET) || (st_q == S_SL1)
                   || (st_q == S_SL2) || (st_q == S_NTTR);
    assign up_st   = (st_q == S_SL3) || (st_q == S_NTUP);
    assign tmo     = act_run && !tmr_q[`ULA_TMR_DIS]
                   && (act_ms_q >= 14'd`ULA_ACT_MS);

    // divider
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            div_q <= 17'h00000;
        end else if (ms_tick || (st_q == S_IDLE && st_d != S_IDLE)) begin
            div_q <= 17'h00000;
        end else begin
            div_q <= div_q + 17'h00001;
        end
    end

    // activation timer runs while the framer is in tone, quiet, SL1, SL2 or NT training
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            act_ms_q <= 14'h0000;
        end else if (!act_run) begin
            act_ms_q <= 14'h0000;
        end else if (ms_tick && act_ms_q != 14'h3fff) begin
            act_ms_q <= act_ms_q + 14'h0001;
        end
    end

    // sync loss timer while the loop is up
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            loss_ms_q <= 9'h000;
        end else if (!up_st || rx_sf_sync) begin
            loss_ms_q <= 9'h000;
        end else if (ms_tick && loss_ms_q != 9'h1ff) begin
            loss_ms_q <= loss_ms_q + 9'h001;
        end
    end

    ////////////////////////////////////////////////////////////////
    // next framer state and status
    always @* begin
        st_d  = st_q;
        lsr_d = lsr_q;
        case (st_q)
            S_IDLE: begin
                if (!ctl_q[`ULA_CTL_NT] && ctl_q[`ULA_CTL_ACT]) begin
                    st_d  = S_TONE;
                    lsr_d = `ULA_ST_PROG;
                end else if (!ctl_q[`ULA_CTL_NT] && rx_tone_det) begin
                    st_d  = S_QUIET;
                    lsr_d = `ULA_ST_PROG;
                end else if (ctl_q[`ULA_CTL_NT] && rx_tone_det) begin
                    st_d  = S_NTTR;
                    lsr_d = `ULA_ST_PROG;
                end
            end
            S_TONE: begin
                if (ms_tick && act_ms_q >= 14'd`ULA_TONE_MS - 14'd1) begin
                    st_d = S_QUIET;
                end
            end
            S_QUIET: begin
                if (!rx_sig_det && !rx_tone_det) begin
                    st_d = S_SL1;
                end
            end
            S_SL1: begin
                if (train_done) begin
                    st_d = S_SL2;
                end
            end
            S_SL2: begin
                if (rx_sig_det && rx_sf_sync && rx_far_act) begin
                    st_d  = S_SL3;
                    lsr_d = `ULA_ST_UP;
                end
            end
            S_NTTR: begin
                // hold in SN2 while framer held
                if (train_done && rx_sf_sync && rx_far_act && !hold_q) begin
                    st_d  = S_NTUP;
                    lsr_d = `ULA_ST_UP;
                end
            end
            S_SL3, S_NTUP: begin
                if (loss_ms_q >= 9'd`ULA_LOSS_MS) begin
                    st_d  = S_IDLE;
                    lsr_d = `ULA_ST_ERR;
                end else if (!rx_sf_sync) begin
                    lsr_d = `ULA_ST_NOSYNC;
                end else if (rx_err_high) begin
                    lsr_d = `ULA_ST_NOTRANS;
                end else begin
                    lsr_d = rx_far_act ? `ULA_ST_UP : `ULA_ST_NOTRANS;
                end
                if (st_q == S_SL3 && ctl_q[`ULA_CTL_DEACT]
                    && !ctl_q[`ULA_CTL_UPDDIS]) begin
                    st_d = S_DEA;
                end
                if (st_q == S_NTUP && rx_far_deact) begin
                    st_d  = S_IDLE;
                    lsr_d = ctl_q[`ULA_CTL_DEACT] ? `ULA_ST_IDLE : `ULA_ST_ERR;
                end
            end
            S_DEA: begin
                if (sf_tick && sf_cnt_q == 2'd`ULA_DEA_SF - 2'd1) begin
                    st_d  = S_IDLE;
                    lsr_d = `ULA_ST_IDLE;
                end
            end
            default: begin
                st_d  = S_IDLE;
                lsr_d = `ULA_ST_IDLE;
            end
        endcase
        if (tmo) begin
            st_d  = S_IDLE;
            lsr_d = `ULA_ST_ERR;
        end
    end

    // framer state, status and dea superframe count
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q     <= S_IDLE;
            lsr_q    <= `ULA_ST_IDLE;
            sf_cnt_q <= 2'b00;
        end else begin
            st_q  <= st_d;
            lsr_q <= lsr_d;
            if (st_q != S_DEA) begin
                sf_cnt_q <= 2'b00;
            end else if (sf_tick) begin
                sf_cnt_q <= sf_cnt_q + 2'b01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // software registers
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctl_q  <= 6'h00;
            swap_q <= 1'b0;
            m4_q   <= 2'b11;
            hold_q <= 1'b0;
            tmr_q  <= 2'b00;
        end else begin
            if (wr_go && address == `ULA_ADR_CONTROL) begin
                ctl_q <= writedata[5:0];
            end
            if (st_q == S_IDLE && st_d != S_IDLE) begin
                ctl_q[`ULA_CTL_ACT] <= 1'b0;
            end
            if (st_q == S_NTUP && tmr_q[`ULA_TMR_AUTO] && !rx_m4_dea) begin
                ctl_q[`ULA_CTL_DEACT] <= 1'b1;
            end
            if (st_q != S_IDLE && st_d == S_IDLE) begin
                ctl_q[`ULA_CTL_DEACT] <= 1'b0;
            end
            if (wr_go && address == `ULA_ADR_CHAN) begin
                swap_q <= writedata[`ULA_CHAN_SWAP];
            end
            if (wr_go && address == `ULA_ADR_M4TX) begin
                m4_q <= writedata[`ULA_M4_ACT:`ULA_M4_DEA];
            end
            if (wr_go && address == `ULA_ADR_FSTATE) begin
                if (writedata[7:4] == `ULA_FS_HOLD) begin
                    hold_q <= 1'b1;
                end else if (writedata[7:4] == `ULA_FS_GO) begin
                    hold_q <= 1'b0;
                end
            end
            if (wr_go && address == `ULA_ADR_TIMER) begin
                tmr_q <= writedata[1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // status-change interrupt, set wins over read clear
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_req <= 1'b0;
        end else if (lsr_d != lsr_q && ctl_q[`ULA_CTL_IRQEN]) begin
            irq_req <= 1'b1;
        end else if (rd_go && address == `ULA_ADR_STATUS) begin
            irq_req <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // line side outputs
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_state   <= 4'h0;
            tx_m4_act  <= 1'b1;
            tx_m4_dea  <= 1'b1;
            data_en    <= 1'b0;
            chan_en    <= 1'b0;
            chan_swap  <= 1'b0;
            warm_start <= 1'b0;
        end else begin
            tx_state <= st_d;
            // m4 bits frozen while update disabled
            if (sf_tick && !ctl_q[`ULA_CTL_UPDDIS]) begin
                tx_m4_act <= m4_q[1];
                tx_m4_dea <= m4_q[0];
            end
            data_en   <= up_st && ctl_q[`ULA_CTL_CUST] && lsr_q == `ULA_ST_UP;
            chan_en   <= up_st;
            chan_swap <= swap_q;
            if (st_q == S_NTUP && rx_far_deact) begin
                warm_start <= ctl_q[`ULA_CTL_DEACT];
            end
        end
    end

endmodule

// file: tb/ula_chk_assertions.sv
// port checker for the loop activation control block
`timescale 1ns/1ps
module ula_chk #(
    parameter MS_CYC = 125000
) (
    // clock, reset and bus
    input wire        clk,
    input wire        rst_b,
    input wire [4:0]  address,
    input wire        read,
    input wire        write,
    input wire [31:0] writedata,
    input wire        waitrequest,
    // line side
    input wire        rx_tone_det,
    input wire        rx_sig_det,
    input wire        rx_sf_sync,
    input wire        rx_far_act,
    input wire        train_done,
    input wire        sf_tick,
    input wire [3:0]  tx_state,
    input wire        data_en,
    input wire        chan_en,
    input wire        chan_swap,
    input wire        irq_req
);
    int tone_n;
    int sf_n;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // cycles spent in tone, superframes spent in teardown
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tone_n <= 0;
            sf_n   <= 0;
        end else begin
            tone_n <= (tx_state == 4'h1) ? tone_n + 1 : 0;
            sf_n   <= (tx_state == 4'h6) ? sf_n + int'(sf_tick) : 0;
        end
    end
    a_wait_single: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("bus access took more than one wait cycle");
    a_act_start: assert property (write && !waitrequest && address == 5'h04 && writedata[3]
        && !writedata[4] && tx_state == 4'h0 |-> ##[1:2] tx_state == 4'h1)
        else $error("activation request did not start the tone");
    a_tone_len: assert property ($fell(tx_state == 4'h1) |->
        tone_n >= 2 * MS_CYC && tone_n <= 3 * MS_CYC + 1)
        else $error("wake-up tone length wrong");
    a_quiet_then_sl1: assert property (tx_state == 4'h2 && !rx_sig_det && !rx_tone_det
        |=> tx_state == 4'h3)
        else $error("no SL1 after far end fell quiet");
    a_train_step: assert property (tx_state == 4'h3 && train_done |=> tx_state == 4'h4)
        else $error("training done did not move to SL2");
    a_linkup_step: assert property (tx_state == 4'h4 && rx_sig_det && rx_sf_sync
        && rx_far_act |=> tx_state == 4'h5 ##[0:1] chan_en)
        else $error("full duplex did not bring the link up");
    a_data_gate: assert property (data_en |-> chan_en)
        else $error("data enabled on a link that is down");
    a_dea_count: assert property ($fell(tx_state == 4'h6) |-> sf_n == 3)
        else $error("teardown did not last three superframes");
    a_swap_follow: assert property (write && !waitrequest && address == 5'h08
        |=> ##1 chan_swap == $past(writedata[0], 2))
        else $error("swap output does not follow its bit");
    a_irq_hold: assert property (irq_req && !(read && !waitrequest && address == 5'h00)
        |=> irq_req)
        else $error("interrupt request dropped without status read");
    c_link_up: cover property (tx_state == 4'h5 && data_en);
    c_teardown: cover property (tx_state == 4'h6);
    c_irq: cover property (irq_req);
endmodule

bind ula_ctrl ula_chk #(.MS_CYC(MS_CYC)) u_chk (.clk, .rst_b, .address, .read, .write,
    .writedata, .waitrequest, .rx_tone_det, .rx_sig_det, .rx_sf_sync, .rx_far_act,
    .train_done, .sf_tick, .tx_state, .data_en, .chan_en, .chan_swap, .irq_req);

// file: tb/ula_far.sv
// far-end line transceiver model on the loop
`timescale 1ns/1ps
module ula_far (
    // clock and reset
    input  wire       clk,
    input  wire       rst_b,
    // near-end framer state and bench knobs
    input  wire [3:0] tx_state,
    input  wire       mute,
    input  wire       lose_sync,
    input  wire       err_on,
    // indications seen by the near end
    output wire       rx_tone_det,
    output wire       rx_sig_det,
    output wire       rx_sf_sync,
    output wire       rx_far_act,
    output wire       rx_err_high,
    output wire       train_done,
    output wire       sf_tick
);
    reg  [3:0] st_q;
    reg  [7:0] cnt_q;
    reg  [3:0] sf_q;
    wire       up   = (st_q == 4'h5) || (st_q == 4'h6);
    wire       sl2r = (st_q == 4'h4) && (cnt_q > 8'h04);
    // age of the near-end state, superframe every 12 cycles
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q  <= 4'h0;
            cnt_q <= 8'h00;
            sf_q  <= 4'h0;
        end else begin
            st_q  <= tx_state;
            cnt_q <= (st_q != tx_state) ? 8'h00 : cnt_q + 8'h01;
            sf_q  <= (sf_q == 4'hb) ? 4'h0 : sf_q + 4'h1;
        end
    end
    // answer tone with TN and SN1, then fall quiet
    assign rx_tone_det = !mute && st_q == 4'h2 && cnt_q < 8'h04;
    assign rx_sig_det  = !mute && ((st_q == 4'h2 && cnt_q < 8'h08) || sl2r || up);
    // far end sends SN3 once the near end sends SL2
    assign rx_sf_sync  = !mute && ((up && !lose_sync) || sl2r);
    assign rx_far_act  = !mute && (up || sl2r);
    assign rx_err_high = up && err_on;
    assign train_done  = !mute && st_q == 4'h3 && cnt_q > 8'h04;
    assign sf_tick     = (sf_q == 4'h0);
endmodule

// file: tb/tb_top.sv
// self-checking bench for the loop activation control block
`timescale 1ns/1ps
module tb_top;
    logic        clk = 1'b0;
    logic        rst_b, read, write, mute, lose_sync, err_on;
    logic [4:0]  address;
    logic [31:0] writedata, v;
    wire  [31:0] readdata;
    wire  [3:0]  tx_state;
    wire         waitrequest, rx_tone_det, rx_sig_det, rx_sf_sync, rx_far_act;
    wire         rx_err_high, train_done, sf_tick, tx_m4_dea, data_en, chan_en;
    wire         chan_swap, irq_req;
    int          err_count, comparisons, cyc;
    // design with shortened millisecond
    ula_ctrl #(.MS_CYC(2)) uut (.clk, .rst_b, .address, .read, .write, .writedata,
        .readdata, .waitrequest, .rx_tone_det, .rx_sig_det, .rx_sf_sync, .rx_far_act,
        .rx_far_deact(1'b0), .rx_err_high, .rx_m4_dea(1'b1), .train_done, .sf_tick,
        .tx_state, .tx_m4_act(), .tx_m4_dea, .data_en, .chan_en, .chan_swap,
        .warm_start(), .irq_req);
    ula_far u_far (.clk, .rst_b, .tx_state, .mute, .lose_sync, .err_on, .rx_tone_det,
        .rx_sig_det, .rx_sf_sync, .rx_far_act, .rx_err_high, .train_done, .sf_tick);
    // clock and hang limit
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            err_count++;
            complete_run;
        end
    end
    task complete_run;
        if (err_count == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task bus_wr(input logic [4:0] a, input logic [31:0] d);
        address <= a;
        writedata <= d;
        write <= 1'b1;
        @(posedge clk);
        while (waitrequest) @(posedge clk);
        write <= 1'b0;
        @(posedge clk);
    endtask
    task bus_rd(input logic [4:0] a, output logic [31:0] d);
        address <= a;
        read <= 1'b1;
        @(posedge clk);
        while (waitrequest) @(posedge clk);
        d = readdata;
        read <= 1'b0;
        @(posedge clk);
    endtask
    task wait_st(input logic [3:0] e, input int lim);
        int i;
        i = 0;
        bus_rd(5'h00, v);
        while (v !== {28'h0, e} && i < lim) begin
            bus_rd(5'h00, v);
            i++;
        end
        chk("status", v, {28'h0, e});
    endtask
    task t_reset_vals;
        bus_rd(5'h00, v); chk("status", v, 32'h0);
        bus_rd(5'h04, v); chk("control", v, 32'h0);
        bus_rd(5'h0c, v); chk("m4 tx", v, 32'hc0);
        bus_rd(5'h1c, v); chk("unmapped", v, 32'h0);
    endtask
    task t_activate;
        bus_wr(5'h04, 32'h28);
        wait_st(4'h1, 20);
        bus_rd(5'h04, v); chk("act req", v[3], 1'b0);
        wait_st(4'hb, 100);
        chk("chan_en", chan_en, 1'b1);
        chk("data_en", data_en, 1'b0);
        chk("irq", irq_req, 1'b0);
    endtask
    task t_cust_swap;
        bus_wr(5'h04, 32'h21);
        repeat (2) @(posedge clk);
        chk("data_en", data_en, 1'b1);
        bus_wr(5'h08, 32'h1);
        @(posedge clk);
        chk("swap", chan_swap, 1'b1);
        bus_wr(5'h08, 32'h0);
        @(posedge clk);
        chk("swap", chan_swap, 1'b0);
        bus_rd(5'h10, v); chk("fstate", v[7:4], 4'h5);
    endtask
    task t_sync_blip;
        lose_sync <= 1'b1;
        repeat (4) @(posedge clk);
        chk("irq", irq_req, 1'b1);
        wait_st(4'h8, 3);
        chk("irq", irq_req, 1'b0);
        lose_sync <= 1'b0;
        wait_st(4'hb, 10);
        chk("data_en", data_en, 1'b1);
    endtask
    task t_err_rate;
        err_on <= 1'b1;
        wait_st(4'ha, 10);
        repeat (1500) @(posedge clk);
        bus_rd(5'h00, v); chk("status", v, 32'ha);
        err_on <= 1'b0;
        wait_st(4'hb, 10);
    endtask
    task t_timed_deact;
        bus_wr(5'h04, 32'h23);
        bus_wr(5'h0c, 32'h80);
        bus_wr(5'h04, 32'h25);
        repeat (2) @(posedge clk iff sf_tick);
        chk("m4 dea", tx_m4_dea, 1'b0);
        wait_st(4'h0, 40);
        chk("chan_en", chan_en, 1'b0);
    endtask
    task t_long_loss;
        lose_sync <= 1'b1;
        wait_st(4'h4, 400);
        lose_sync <= 1'b0;
        chk("chan_en", chan_en, 1'b0);
    endtask
    task t_timer_off;
        bus_wr(5'h14, 32'h1);
        mute <= 1'b1;
        bus_wr(5'h04, 32'h08);
        repeat (31000) @(posedge clk);
        bus_rd(5'h00, v); chk("status", v, 32'h1);
        rst_b <= 1'b0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_reset_vals;
    endtask
    task t_timeout;
        bus_wr(5'h04, 32'h08);
        wait_st(4'h4, 10500);
        chk("state", tx_state, 4'h0);
    endtask
    // reset, then scenarios in order
    initial begin
        {rst_b, read, write, mute, lose_sync, err_on} = 6'h00;
        {address, writedata, err_count, comparisons, cyc} = '0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_reset_vals;
        t_activate;
        t_cust_swap;
        t_sync_blip;
        t_err_rate;
        t_timed_deact;
        t_activate;
        t_long_loss;
        t_timer_off;
        t_timeout;
        complete_run;
    end
endmodule
